// ### common/fault_defs.svh
// offsets, field positions, reset values and widths of the fault status bank
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

`define FS_ADDR_FIRST 8'h41
`define FS_ADDR_SECOND 8'h42
`define FS_RESET_VALUE 8'h00
`define FS_UNMAPPED_VALUE 8'h00

`define FS_MEAS_WIDTH 8
`define FS_TACH_WIDTH 16
`define FS_RAIL_COUNT 4
`define FS_ZONE_COUNT 3
`define FS_FAN_COUNT 4

`define FS1_ZONE_ONE_BIT 4
`define FS1_ZONE_TWO_BIT 5
`define FS1_ZONE_THREE_BIT 6
`define FS1_SUMMARY_BIT 7

`define FS2_TWELVE_BIT 0
`define FS2_RESERVED_BIT 1
`define FS2_FAN_BASE_BIT 2
`define FS2_DIODE_ONE_BIT 6
`define FS2_DIODE_TWO_BIT 7

`endif

// ### common/fault_pkg.sv
// types shared by the fault status bank and its neighbours
`include "fault_defs.svh"
package fault_pkg;

  typedef logic [`FS_MEAS_WIDTH-1:0] meas_t;
  typedef logic [`FS_TACH_WIDTH-1:0] tach_t;

  // rail index 0: 2.5 V, 1: core supply, 2: 3.3 V, 3: 5 V
  typedef struct packed {
    meas_t v12;
    logic [`FS_RAIL_COUNT-1:0][`FS_MEAS_WIDTH-1:0] rail;
  } volt_set_t;

  // zone index 0: remote diode 1, 1: internal sensor, 2: remote diode 2
  typedef logic [`FS_ZONE_COUNT-1:0][`FS_MEAS_WIDTH-1:0] temp_set_t;

  // zone three shares the zone two low limit, so only two low limits exist
  typedef struct packed {
    meas_t low_one;
    meas_t low_two;
    temp_set_t high;
  } temp_limit_t;

  typedef logic [`FS_FAN_COUNT-1:0][`FS_TACH_WIDTH-1:0] tach_set_t;

  typedef struct packed {
    logic diode_one_fault_flag;
    logic diode_two_fault_flag;
  } diode_fault_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_access_t;

endpackage

// ### hdl/window_compare.sv
// window comparator: flags a reading outside its low and high limits
module window_compare
  import fault_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter bit SIGNED_CMP = 1'b0,
  parameter bit LOW_INCLUSIVE = 1'b1
)
(
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] low,
  input wire logic [WIDTH-1:0] high,
  output logic out_of_window
);

  logic below_low;
  logic above_high;
  logic at_low;

  // temperatures are two's complement, voltages and counts are unsigned
  assign below_low = SIGNED_CMP ? ($signed(value) < $signed(low)) : (value < low);
  assign above_high = SIGNED_CMP ? ($signed(value) > $signed(high)) : (value > high);
  assign at_low = LOW_INCLUSIVE && (value == low);
  assign out_of_window = below_low | at_low | above_high;

endmodule

// ### hdl/sticky_status.sv
// sticky fault bits that clear on read only where the fault has gone
`include "fault_defs.svh"
module sticky_status
  import fault_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] fault_now,
  input wire logic clear_on_read,
  output logic [WIDTH-1:0] status_reg
);

  logic [WIDTH-1:0] status_next;

  // a live fault is always or'ed in, so a clear never swallows it
  assign status_next = clear_on_read ? fault_now : (status_reg | fault_now);

  // status bits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status_reg <= WIDTH'(`FS_RESET_VALUE);
    else
      status_reg <= status_next;
  end

endmodule

// ### hdl/monitor_fault_status_flags.sv
// fault status bank: two sticky, read-cleared monitor fault registers
`include "fault_defs.svh"

// Overview of operation
// - a first-register bit sets when its reading leaves its limit window.
// - several faults show together in one register at read time.
// - a set bit stays set until its register is read; first-register bit 7 until the second is read.
// - a read clears each bit whose fault is gone, keeps persisting ones.
// - both registers are read only; writes change nothing.
// - rail bits 0-3 set at or below low limit, or above high limit.
// - bit 4 sets for remote diode 1 at or below zone 1 low, above high.
// - diode open or short faults force the zone 1 and zone 3 bits.
// - bit 5 sets for internal sensor at or below zone 2 low, above high.
// - bit 6 sets for diode 2 at or below zone 2 low, above zone 3 high.
// - first-register bit 7 reads 1 whenever any second-register bit is set.
// - second bit 0 sets when 12 V is below low or above high limit.
// - second bits 2-5 set when a fan period count exceeds its minimum.
// - the second register also carries the temperature sensor error flags.
// - second bit 6 sets on a remote diode 1 fault, which also sets bit 4.
// - second bit 7 sets on a remote diode 2 fault, which also sets bit 6.
module monitor_fault_status_flags
  import fault_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire host_access_t host_req,
  input wire volt_set_t volt_meas,
  input wire volt_set_t volt_low,
  input wire volt_set_t volt_high,
  input wire temp_set_t temp_meas,
  input wire temp_limit_t temp_limit,
  input wire tach_set_t tach_count,
  input wire tach_set_t tach_min,
  input wire diode_fault_t diode_fault,
  output logic [7:0] rdata_reg,
  output logic rvalid_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // address decoding

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  logic rd_first;
  logic rd_second;
  logic rd_unmapped;

  // a register is read only when the host asks for its offset; any other read is unmapped
  assign rd_first = host_req.rd_en && addr_hit(host_req.addr, `FS_ADDR_FIRST);
  assign rd_second = host_req.rd_en && addr_hit(host_req.addr, `FS_ADDR_SECOND);
  assign rd_unmapped = host_req.rd_en && !rd_first && !rd_second;

  ////////////////////////////////////////////////////////////////////////////
  // comparisons of readings against their limits

  logic [`FS_RAIL_COUNT-1:0] rail_fault;
  logic twelve_fault;
  logic [`FS_ZONE_COUNT-1:0] zone_fault;
  logic [`FS_FAN_COUNT-1:0] fan_fault;
  meas_t [`FS_ZONE_COUNT-1:0] zone_low;

  // the four low rails count a reading equal to the low limit as a fault
  for (genvar i = 0; i < `FS_RAIL_COUNT; i++)
  begin : g_rail
    window_compare #(
      .WIDTH(`FS_MEAS_WIDTH),
      .SIGNED_CMP(1'b0),
      .LOW_INCLUSIVE(1'b1)
    ) u_rail_cmp (
      .value(volt_meas.rail[i]),
      .low(volt_low.rail[i]),
      .high(volt_high.rail[i]),
      .out_of_window(rail_fault[i])
    );
  end

  // the 12 V rail is strict on both sides, unlike the others
  window_compare #(
    .WIDTH(`FS_MEAS_WIDTH),
    .SIGNED_CMP(1'b0),
    .LOW_INCLUSIVE(1'b0)
  ) u_twelve_cmp (
    .value(volt_meas.v12),
    .low(volt_low.v12),
    .high(volt_high.v12),
    .out_of_window(twelve_fault)
  );

  // zone three deliberately borrows the zone two low limit
  assign zone_low[0] = temp_limit.low_one;
  assign zone_low[1] = temp_limit.low_two;
  assign zone_low[2] = temp_limit.low_two;

  // temperature limits are two's complement, so compare signed
  for (genvar z = 0; z < `FS_ZONE_COUNT; z++)
  begin : g_zone
    window_compare #(
      .WIDTH(`FS_MEAS_WIDTH),
      .SIGNED_CMP(1'b1),
      .LOW_INCLUSIVE(1'b1)
    ) u_zone_cmp (
      .value(temp_meas[z]),
      .low(zone_low[z]),
      .high(temp_limit.high[z]),
      .out_of_window(zone_fault[z])
    );
  end

  // a long period count means a slow fan; a zero low bound never trips
  for (genvar f = 0; f < `FS_FAN_COUNT; f++)
  begin : g_fan
    window_compare #(
      .WIDTH(`FS_TACH_WIDTH),
      .SIGNED_CMP(1'b0),
      .LOW_INCLUSIVE(1'b0)
    ) u_fan_cmp (
      .value(tach_count[f]),
      .low(tach_t'(0)),
      .high(tach_min[f]),
      .out_of_window(fan_fault[f])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // live fault vectors

  logic [6:0] first_cond;
  logic [7:0] second_cond;

  // every comparison lands in its own bit, so faults stack up freely
  assign first_cond[`FS_RAIL_COUNT-1:0] = rail_fault;
  assign first_cond[`FS1_ZONE_ONE_BIT] = zone_fault[0]
    | diode_fault.diode_one_fault_flag;
  assign first_cond[`FS1_ZONE_TWO_BIT] = zone_fault[1];
  assign first_cond[`FS1_ZONE_THREE_BIT] = zone_fault[2]
    | diode_fault.diode_two_fault_flag;

  // second register: 12 V, reserved zero, fans, diode error flags
  assign second_cond[`FS2_TWELVE_BIT] = twelve_fault;
  assign second_cond[`FS2_RESERVED_BIT] = 1'b0;
  assign second_cond[`FS2_FAN_BASE_BIT +: `FS_FAN_COUNT] = fan_fault;
  assign second_cond[`FS2_DIODE_ONE_BIT] = diode_fault.diode_one_fault_flag;
  assign second_cond[`FS2_DIODE_TWO_BIT] = diode_fault.diode_two_fault_flag;

  ////////////////////////////////////////////////////////////////////////////
  // sticky registers

  logic [6:0] first_status;
  logic [7:0] second_status;
  logic [7:0] first_view;

  // writes reach neither register: only reads clear, nothing stores
  sticky_status #(
    .WIDTH(7)
  ) u_first_status (
    .clk(clk),
    .arst_n(arst_n),
    .fault_now(first_cond),
    .clear_on_read(rd_first),
    .status_reg(first_status)
  );

  sticky_status #(
    .WIDTH(8)
  ) u_second_status (
    .clk(clk),
    .arst_n(arst_n),
    .fault_now(second_cond),
    .clear_on_read(rd_second),
    .status_reg(second_status)
  );

  // bit 7 follows the second register, so it clears only when that does
  assign first_view = {|second_status, first_status};

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdata_next;

  // data is the value before this read's clear; unmapped reads give zero
  assign rdata_next = rd_first ? first_view
    : rd_second ? second_status
    : `FS_UNMAPPED_VALUE;

  // read port flops; data holds between reads
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= `FS_RESET_VALUE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= host_req.rd_en;
      if (host_req.rd_en)
        rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic rail0_out;
  assign rail0_out = (volt_meas.rail[0] <= volt_low.rail[0])
    || (volt_meas.rail[0] > volt_high.rail[0]);

  a_rail_sets_bit: assert property (@(posedge clk) disable iff (!arst_n)
    rail0_out |=> first_status[0])
    else $error("rail 0 fault did not set its bit");

  a_twelve_strict: assert property (@(posedge clk) disable iff (!arst_n)
    (volt_meas.v12 == volt_low.v12) && (volt_meas.v12 <= volt_high.v12)
      && !second_status[0] |=> !second_status[0])
    else $error("12 V bit set at equal low limit");

  a_sticky_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!rd_first && first_status != 7'h00) |=> ((first_status & $past(first_status))
      == $past(first_status)))
    else $error("first status bit dropped without a read");

  a_read_clears: assert property (@(posedge clk) disable iff (!arst_n)
    rd_second |=> second_status == $past(second_cond))
    else $error("second status not reduced to live faults after read");

  a_clear_keeps_live: assert property (@(posedge clk) disable iff (!arst_n)
    rd_first |=> (first_status & $past(first_cond)) == $past(first_cond))
    else $error("fault lost during read clear");

  a_write_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    host_req.wr_en && !host_req.rd_en && first_cond == 7'h00
      && second_cond == 8'h00 |=> $stable(first_status) && $stable(second_status))
    else $error("write changed a status register");

  a_summary_read: assert property (@(posedge clk) disable iff (!arst_n)
    rd_first |=> rvalid_reg && rdata_reg[`FS1_SUMMARY_BIT] == |$past(second_status))
    else $error("summary bit does not mirror second register");

  a_diode_one_both: assert property (@(posedge clk) disable iff (!arst_n)
    diode_fault.diode_one_fault_flag |=> first_status[`FS1_ZONE_ONE_BIT]
      && second_status[`FS2_DIODE_ONE_BIT])
    else $error("diode 1 fault did not set both bits");

  a_diode_two_both: assert property (@(posedge clk) disable iff (!arst_n)
    diode_fault.diode_two_fault_flag |=> first_status[`FS1_ZONE_THREE_BIT]
      && second_status[`FS2_DIODE_TWO_BIT])
    else $error("diode 2 fault did not set both bits");

  a_fan_stall: assert property (@(posedge clk) disable iff (!arst_n)
    tach_count[3] > tach_min[3] |=> second_status[`FS2_FAN_BASE_BIT + 3])
    else $error("fan 4 slow count did not set its bit");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rd_second |=> !rdata_reg[`FS2_RESERVED_BIT])
    else $error("reserved bit read as one");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rd_unmapped |=> rdata_reg == `FS_UNMAPPED_VALUE)
    else $error("unmapped read returned data");

  // read data must be the held status, taken before the read's own clear
  a_first_read_data: assert property (@(posedge clk) disable iff (!arst_n)
    rd_first |=> rdata_reg[6:0] == $past(first_status))
    else $error("first register read returned wrong bits");

  a_second_read_data: assert property (@(posedge clk) disable iff (!arst_n)
    rd_second |=> rdata_reg == $past(second_status))
    else $error("second register read returned wrong bits");

  a_valid_follows_read: assert property (@(posedge clk) disable iff (!arst_n)
    host_req.rd_en |=> rvalid_reg)
    else $error("read not answered one cycle later");

  a_valid_single: assert property (@(posedge clk) disable iff (!arst_n)
    !host_req.rd_en |=> !rvalid_reg)
    else $error("valid raised without a read");

  a_zone_one_low: assert property (@(posedge clk) disable iff (!arst_n)
    temp_meas[0] == temp_limit.low_one |=> first_status[`FS1_ZONE_ONE_BIT])
    else $error("zone 1 reading at its low limit did not set bit 4");

  // zone three must use the zone two low limit, not the zone one one
  a_zone_three_low: assert property (@(posedge clk) disable iff (!arst_n)
    $signed(temp_meas[2]) <= $signed(temp_limit.low_two)
      |=> first_status[`FS1_ZONE_THREE_BIT])
    else $error("zone 3 reading at or below shared low limit did not set bit 6");

  a_twelve_sets: assert property (@(posedge clk) disable iff (!arst_n)
    volt_meas.v12 < volt_low.v12 || volt_meas.v12 > volt_high.v12
      |=> second_status[`FS2_TWELVE_BIT])
    else $error("12 V reading outside its window did not set bit 0");

  c_clear_persist: cover property (@(posedge clk) disable iff (!arst_n)
    rd_first && first_status[0] && first_cond[0]);

  c_multi_fault: cover property (@(posedge clk) disable iff (!arst_n)
    rd_second && $countones(second_status) > 1);

  c_fault_gone: cover property (@(posedge clk) disable iff (!arst_n)
    first_status[1] && !first_cond[1] ##1 rd_first);

  c_unmapped: cover property (@(posedge clk) disable iff (!arst_n) rd_unmapped);

endmodule

// ### sim/host_model.sv
// management bus host model: single-register reads and writes to the bank
module host_model
  import fault_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata_reg,
  input wire logic rvalid_reg,
  output host_access_t host_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one request per call, held for exactly one edge; the answer is taken one
  // edge later; idle address and data lines show the inverse so stale values never look valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] d, output logic v);
    @(negedge clk);
    host_req.rd_en = !wr;
    host_req.wr_en = wr;
    host_req.addr = a;
    host_req.wdata = wd;
    @(negedge clk);
    v = rvalid_reg;
    d = rdata_reg;
    host_req.rd_en = 1'b0;
    host_req.wr_en = 1'b0;
    host_req.addr = ~a;
    host_req.wdata = ~wd;
  endtask
endmodule

// ### sim/test_monitor_fault_status_flags.sv
// self-checking bench for the fault status bank
module test_monitor_fault_status_flags
  import fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  host_access_t host_req;
  volt_set_t volt_meas, volt_low, volt_high;
  temp_set_t temp_meas;
  temp_limit_t temp_limit;
  tach_set_t tach_count, tach_min;
  diode_fault_t diode_fault;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  int failures = 0;
  int samples_checked = 0;

  initial forever #5 clk = ~clk;

  monitor_fault_status_flags DUT (.clk(clk), .arst_n(arst_n), .host_req(host_req),
    .volt_meas(volt_meas), .volt_low(volt_low), .volt_high(volt_high),
    .temp_meas(temp_meas), .temp_limit(temp_limit), .tach_count(tach_count),
    .tach_min(tach_min), .diode_fault(diode_fault), .rdata_reg(rdata_reg),
    .rvalid_reg(rvalid_reg));

  host_model host (.clk(clk), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
    .host_req(host_req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // every reading well inside its window; zone lows differ to tell them apart
  task automatic quiet();
    volt_meas = {5{8'h80}};
    temp_meas = {3{8'h20}};
    tach_count = {4{16'h0800}};
    diode_fault = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.access(1'b0, a, 8'h00, d, v);
    check("read valid", 8'h01, {7'h00, v});
    check("read data", exp, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] d;
    logic v;
    host.access(1'b1, a, wd, d, v);
    check("write valid", 8'h00, {7'h00, v});
  endtask

  // fault held two cycles then removed: sticky until read, then cleared
  task automatic probe(input logic [7:0] e1, input logic [7:0] e2);
    repeat (2) @(negedge clk);
    quiet();
    rd(8'h41, {|e2, e1[6:0]});
    rd(8'h42, e2);
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
  endtask

  task automatic zcase(input int z, input logic [7:0] v, input logic [7:0] e);
    temp_meas[z] = v;
    probe(e, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_comparators();
    for (int i = 0; i < 4; i++)
    begin
      volt_meas.rail[i] = 8'h40;
      probe(8'(1 << i), 8'h00);
      volt_meas.rail[i] = 8'h41;
      probe(8'h00, 8'h00);
      volt_meas.rail[i] = 8'hC1;
      probe(8'(1 << i), 8'h00);
      volt_meas.rail[i] = 8'hC0;
      probe(8'h00, 8'h00);
      tach_count[i] = 16'h1000;
      probe(8'h00, 8'h00);
      tach_count[i] = 16'h1001;
      probe(8'h00, 8'(4 << i));
    end
    // signed limits: lows sit below zero, so an unsigned compare misfires
    zcase(0, 8'hE0, 8'h10);
    zcase(0, 8'hF0, 8'h00);
    zcase(0, 8'h51, 8'h10);
    zcase(1, 8'hF0, 8'h20);
    zcase(1, 8'hF1, 8'h00);
    zcase(1, 8'h51, 8'h20);
    zcase(2, 8'hE1, 8'h40);
    zcase(2, 8'hF1, 8'h00);
    zcase(2, 8'h51, 8'h40);
    zcase(2, 8'h50, 8'h00);
    // the 12 V rail uses strict bounds on both sides
    volt_meas.v12 = 8'h40;
    probe(8'h00, 8'h00);
    volt_meas.v12 = 8'h3F;
    probe(8'h00, 8'h01);
    volt_meas.v12 = 8'hC0;
    probe(8'h00, 8'h00);
    volt_meas.v12 = 8'hC1;
    probe(8'h00, 8'h01);
    $display("test comparators done");
  endtask

  task automatic t_diodes_and_multi();
    diode_fault.diode_one_fault_flag = 1'b1;
    probe(8'h10, 8'h40);
    diode_fault.diode_two_fault_flag = 1'b1;
    probe(8'h40, 8'h80);
    volt_meas.rail[0] = 8'h00;
    tach_count[3] = 16'hFFFF;
    diode_fault.diode_two_fault_flag = 1'b1;
    probe(8'h41, 8'hA0);
    $display("test diodes and multi done");
  endtask

  task automatic t_persist();
    volt_meas.rail[2] = 8'h30;
    tach_count[1] = 16'hFFFF;
    repeat (2) @(negedge clk);
    rd(8'h41, 8'h84);
    rd(8'h42, 8'h08);
    rd(8'h42, 8'h08);
    rd(8'h41, 8'h84);
    quiet();
    rd(8'h41, 8'h84);
    rd(8'h42, 8'h08);
    rd(8'h41, 8'h00);
    $display("test persist done");
  endtask

  // a one-cycle fault that lands exactly in the read cycle
  task automatic t_race();
    logic [7:0] d;
    logic v;
    fork
      host.access(1'b0, 8'h41, 8'h00, d, v);
      begin
        @(negedge clk);
        volt_meas.rail[3] = 8'hFF;
        @(negedge clk);
        quiet();
      end
    join
    check("race read", 8'h00, d);
    rd(8'h41, 8'h08);
    rd(8'h41, 8'h00);
    $display("test race done");
  endtask

  task automatic t_writes();
    volt_meas.rail[1] = 8'h10;
    repeat (2) @(negedge clk);
    quiet();
    wr(8'h41, 8'h00);
    wr(8'h42, 8'hFF);
    rd(8'h43, 8'h00);
    rd(8'h42, 8'h00);
    rd(8'h41, 8'h02);
    rd(8'h41, 8'h00);
    $display("test writes done");
  endtask

  // a reset in mid-run must wipe set bits and stale read data alike
  task automatic t_reset();
    volt_meas.rail[0] = 8'h00;
    tach_count[0] = 16'hFFFF;
    repeat (2) @(negedge clk);
    rd(8'h41, 8'h81);
    quiet();
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("reset data", 8'h00, rdata_reg);
    check("reset valid", 8'h00, {7'h00, rvalid_reg});
    arst_n = 1'b1;
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
    $display("test reset mid-run done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // limits stay fixed; only readings and diode faults move
  initial
  begin
    volt_low = {5{8'h40}};
    volt_high = {5{8'hC0}};
    temp_limit = '{low_one: 8'hE0, low_two: 8'hF0, high: {3{8'h50}}};
    tach_min = {4{16'h1000}};
    quiet();
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
    $display("test reset done");
    t_comparators();
    t_diodes_and_multi();
    t_persist();
    t_race();
    t_writes();
    t_reset();
    report_and_stop();
  end

  // the tests need some 470 cycles, about 4.7 us; this span leaves wide margin
  initial
  begin
    #200us;
    failures++;
    report_and_stop();
  end
endmodule
